// ==== design/spis_status_flags.sv ====
// Operation
// - Busy flag at bit 24 reads 1 during a frame, 0 when idle.
// - Match flag at bit 13 sets when a received word meets match setting.
// - Receive error flag at bit 12 sets on receive FIFO overflow only.
// - Transmit error flag at bit 11 sets on transmit FIFO underrun.
// - Master mode: transfer done at bit 10 on idle with empty transmit FIFO.
// - Frame done flag at bit 9 sets when peripheral select negates.
// - Word done flag at bit 8 sets when a word's last bit is sampled.
// - Receive data flag at bit 1 while receive count exceeds its watermark.
// - Transmit request at bit 0 while transmit count at or below watermark.
`timescale 1ns/100ps
`include "spis_defines.svh"

module spis_status_flags
  import spis_pkg::*;
#(
  parameter int WORD_BITS = 32,
  parameter int DEPTH     = 8
) (
  // Clock and reset
  input  logic        clk,
  input  logic        rst_n,
  // Avalon-MM slave
  input  logic [4:0]  avs_address,
  input  logic        avs_read,
  input  logic        avs_write,
  input  logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic        avs_waitrequest,
  // Serial link
  input  logic        sck,
  input  logic        sdi,
  input  logic        peripheralSelectN,
  output logic        sdo,
  output logic        sdoOe,
  // Interrupt request
  output logic        irq
);

  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    spis_state_t st;
    logic [31:0] rxShift;
    logic [31:0] txShift;
    logic [5:0]  bitCnt;
    logic        needLoad;
    logic [5:0]  evt;
    logic [31:0] ien;
    logic        masterMode;
    logic [1:0]  matchCfg;
    logic [3:0]  tx_watermark;
    logic [3:0]  rx_watermark;
    logic [31:0] matchA;
    logic [31:0] matchB;
    logic        rdPend;
    logic        rdPop;
    logic [31:0] rdData;
    logic        irq;
  } spis_main_st_t;

  spis_main_st_t r;
  spis_main_st_t n;

  // ----------------------------------------------------------------
  // Link sampling and FIFOs
  // ----------------------------------------------------------------
  logic [2:0] pinLvl;
  logic [2:0] pinRise;
  logic [2:0] pinFall;
  logic       sckRise;
  logic       sckFall;
  logic       selFall;
  logic       selRise;
  logic       sdiLvl;

  // Select idles high, clock and data idle low
  spis_sync #(.W(3), .RESET_VAL(3'h4)) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .pins  ({peripheralSelectN, sck, sdi}),
    .level (pinLvl),
    .rise  (pinRise),
    .fall  (pinFall)
  );

  assign sdiLvl  = pinLvl[0];
  assign sckRise = pinRise[1];
  assign sckFall = pinFall[1];
  assign selFall = pinFall[2];
  assign selRise = pinRise[2];

  spis_fifo_if #(.W(32), .CW(CW)) txIf ();
  spis_fifo_if #(.W(32), .CW(CW)) rxIf ();

  spis_fifo #(.W(32), .DEPTH(DEPTH)) u_txFifo (
    .clk   (clk),
    .rst_n (rst_n),
    .fif   (txIf.store)
  );

  spis_fifo #(.W(32), .DEPTH(DEPTH)) u_rxFifo (
    .clk   (clk),
    .rst_n (rst_n),
    .fif   (rxIf.store)
  );

  // ----------------------------------------------------------------
  // Status word and bus decode
  // ----------------------------------------------------------------
  logic        busy;
  logic        rxDataFlag;
  logic        txReqFlag;
  logic [31:0] statusWord;
  logic        wrTx;
  logic        wrAcc;
  logic        rdAcc;

  // Compares a received word against the selected match values
  function automatic logic matchHit(input logic [31:0] w, input logic [1:0] cfg,
                                    input logic [31:0] a, input logic [31:0] b);
    case (spis_match_t'(cfg))
      SPIS_MATCH_A:      matchHit = (w == a);
      SPIS_MATCH_B:      matchHit = (w == b);
      SPIS_MATCH_EITHER: matchHit = (w == a) || (w == b);
      default:           matchHit = 1'b0;
    endcase
  endfunction

  // Live flags and the assembled status word
  assign busy       = (r.st == SPIS_FRAME);
  assign rxDataFlag = (rxIf.count > CW'(r.rx_watermark));
  assign txReqFlag  = (txIf.count <= CW'(r.tx_watermark));

  always_comb
  begin
    statusWord                         = '0;
    statusWord[`SPIS_BIT_BUSY]         = busy;
    statusWord[`SPIS_EVT_MSB:`SPIS_EVT_LSB] = r.evt;
    statusWord[`SPIS_BIT_RXDATA]       = rxDataFlag;
    statusWord[`SPIS_BIT_TXREQ]        = txReqFlag;
  end

  // Reads take one wait state; a transmit write waits while full
  assign wrTx            = avs_write && (avs_address == `SPIS_OFF_TXDATA);
  assign avs_waitrequest = (avs_read && !r.rdPend) || (wrTx && !txIf.pushReady);
  assign wrAcc           = avs_write && !avs_waitrequest;
  assign rdAcc           = avs_read && r.rdPend;
  assign avs_readdata    = r.rdData;

  // FIFO strobes from the bus
  assign txIf.pushValid = wrAcc && wrTx;
  assign txIf.pushData  = avs_writedata;
  assign rxIf.popReady  = rdAcc && r.rdPop;                     // Only a word that was returned

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic [5:0]  evtSet;
  logic [5:0]  evtClr;
  logic        loadReq;
  logic        rxPush;
  logic        txPop;
  logic [31:0] word;

  assign rxIf.pushValid = rxPush;
  assign rxIf.pushData  = word;
  assign txIf.popReady  = txPop;

  always_comb
  begin
    n       = r;
    evtSet  = '0;
    evtClr  = '0;
    loadReq = 1'b0;
    rxPush  = 1'b0;
    txPop   = 1'b0;
    word    = {r.rxShift[30:0], sdiLvl};

    // Frame tracking and shifting
    case (r.st)
      SPIS_IDLE:
      begin
        if (selFall)
        begin
          n.st      = SPIS_FRAME;
          n.bitCnt  = '0;
          n.rxShift = '0;
          loadReq   = 1'b1;
        end
      end
      SPIS_FRAME:
      begin
        if (selRise)
        begin
          n.st = SPIS_IDLE;
          evtSet[`SPIS_BIT_FRAME - `SPIS_EVT_LSB] = 1'b1;
          if (r.masterMode && !txIf.popValid)
            evtSet[`SPIS_BIT_XFER - `SPIS_EVT_LSB] = 1'b1;
        end
        else
        begin
          if (sckRise)
          begin
            if (r.bitCnt == 6'(WORD_BITS - 1))
            begin
              rxPush     = 1'b1;
              n.bitCnt   = '0;
              n.rxShift  = '0;
              n.needLoad = 1'b1;
              evtSet[`SPIS_BIT_WORD - `SPIS_EVT_LSB] = 1'b1;
              if (!rxIf.pushReady)
                evtSet[`SPIS_BIT_RXERR - `SPIS_EVT_LSB] = 1'b1;
              if (matchHit(word, r.matchCfg, r.matchA, r.matchB))
                evtSet[`SPIS_BIT_MATCH - `SPIS_EVT_LSB] = 1'b1;
            end
            else
            begin
              n.bitCnt  = 6'(r.bitCnt + 1'b1);
              n.rxShift = word;
            end
          end
          if (sckFall)
          begin
            if (r.needLoad)
              loadReq = 1'b1;
            else
              n.txShift = {r.txShift[30:0], 1'b0};
          end
        end
      end
      default:
        n.st = SPIS_IDLE;
    endcase

    // Next transmit word, or underrun when none is queued
    if (loadReq)
    begin
      n.needLoad = 1'b0;
      if (txIf.popValid)
      begin
        txPop     = 1'b1;
        n.txShift = txIf.popData << (32 - WORD_BITS);
      end
      else
      begin
        n.txShift = '0;
        evtSet[`SPIS_BIT_TXERR - `SPIS_EVT_LSB] = 1'b1;
      end
    end

    // Register writes
    if (wrAcc)
    begin
      if (avs_address == `SPIS_OFF_STATUS)
        evtClr = avs_writedata[`SPIS_EVT_MSB:`SPIS_EVT_LSB];
      else if (avs_address == `SPIS_OFF_IEN)
        n.ien = avs_writedata & `SPIS_IEN_MASK;
      else if (avs_address == `SPIS_OFF_CTRL)
      begin
        n.masterMode = avs_writedata[`SPIS_CTRL_MASTER];
        n.matchCfg   = avs_writedata[`SPIS_CTRL_MCFG_MSB:`SPIS_CTRL_MCFG_LSB];
      end
      else if (avs_address == `SPIS_OFF_WATER)
      begin
        n.tx_watermark = avs_writedata[`SPIS_WATER_TX_MSB:`SPIS_WATER_TX_LSB];
        n.rx_watermark = avs_writedata[`SPIS_WATER_RX_MSB:`SPIS_WATER_RX_LSB];
      end
      else if (avs_address == `SPIS_OFF_MATCHA)
        n.matchA = avs_writedata;
      else if (avs_address == `SPIS_OFF_MATCHB)
        n.matchB = avs_writedata;
    end

    // Set wins over a clear in the same cycle
    n.evt = (r.evt & ~evtClr) | evtSet;

    // Read capture, answered one cycle later
    if (avs_read && !r.rdPend)
    begin
      n.rdPend = 1'b1;
      n.rdPop  = (avs_address == `SPIS_OFF_RXDATA) && rxIf.popValid;
      if (avs_address == `SPIS_OFF_STATUS)
        n.rdData = statusWord;
      else if (avs_address == `SPIS_OFF_IEN)
        n.rdData = r.ien;
      else if (avs_address == `SPIS_OFF_CTRL)
        n.rdData = {29'h0, r.matchCfg, r.masterMode};
      else if (avs_address == `SPIS_OFF_WATER)
        n.rdData = {12'h0, r.rx_watermark, 12'h0, r.tx_watermark};
      else if (avs_address == `SPIS_OFF_MATCHA)
        n.rdData = r.matchA;
      else if (avs_address == `SPIS_OFF_MATCHB)
        n.rdData = r.matchB;
      else if (avs_address == `SPIS_OFF_RXDATA)
        n.rdData = rxIf.popValid ? rxIf.popData : 32'h0;
      else
        n.rdData = 32'h0;
    end
    else if (rdAcc)
      n.rdPend = 1'b0;

    // Interrupt from enabled flags
    n.irq = |(statusWord & r.ien);
  end

  // ----------------------------------------------------------------
  // Outputs and state register
  // ----------------------------------------------------------------
  assign sdo   = r.txShift[31];
  assign sdoOe = busy;
  assign irq   = r.irq;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      r          <= '0;
      r.st       <= SPIS_IDLE;
      r.ien      <= 32'(`SPIS_RST_IEN);
      r.matchCfg <= `SPIS_RST_MCFG;
      r.tx_watermark  <= `SPIS_RST_WATER;
      r.rx_watermark  <= `SPIS_RST_WATER;
      r.matchA   <= `SPIS_RST_MATCH;
      r.matchB   <= `SPIS_RST_MATCH;
    end
    else
    begin
      r <= n;
    end
  end
endmodule

// ==== design/spis_defines.svh ====
`ifndef SPIS_DEFINES_SVH
`define SPIS_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define SPIS_OFF_STATUS 5'h00
`define SPIS_OFF_IEN    5'h04
`define SPIS_OFF_CTRL   5'h08
`define SPIS_OFF_WATER  5'h0c
`define SPIS_OFF_MATCHA 5'h10
`define SPIS_OFF_MATCHB 5'h14
`define SPIS_OFF_TXDATA 5'h18
`define SPIS_OFF_RXDATA 5'h1c

// ----------------------------------------------------------------
// Status word bit positions
// ----------------------------------------------------------------
`define SPIS_BIT_BUSY   24
`define SPIS_BIT_MATCH  13
`define SPIS_BIT_RXERR  12
`define SPIS_BIT_TXERR  11
`define SPIS_BIT_XFER   10
`define SPIS_BIT_FRAME  9
`define SPIS_BIT_WORD   8
`define SPIS_BIT_RXDATA 1
`define SPIS_BIT_TXREQ  0
`define SPIS_EVT_LSB    8
`define SPIS_EVT_MSB    13
`define SPIS_IEN_MASK   32'h0000_3f03

// ----------------------------------------------------------------
// Control and watermark field positions
// ----------------------------------------------------------------
`define SPIS_CTRL_MASTER    0
`define SPIS_CTRL_MCFG_LSB  1
`define SPIS_CTRL_MCFG_MSB  2
`define SPIS_WATER_TX_LSB   0
`define SPIS_WATER_TX_MSB   3
`define SPIS_WATER_RX_LSB   16
`define SPIS_WATER_RX_MSB   19

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define SPIS_RST_IEN    14'h0000
`define SPIS_RST_MCFG   2'h0
`define SPIS_RST_WATER  4'h0
`define SPIS_RST_MATCH  32'h0000_0000

`endif

// ==== design/spis_pkg.sv ====
package spis_pkg;

  // Link state of the frame tracker
  typedef enum logic [0:0] {
    SPIS_IDLE,
    SPIS_FRAME
  } spis_state_t;

  // Match comparator selection
  typedef enum logic [1:0] {
    SPIS_MATCH_OFF,
    SPIS_MATCH_A,
    SPIS_MATCH_B,
    SPIS_MATCH_EITHER
  } spis_match_t;

endpackage

// ==== design/spis_fifo_if.sv ====
`timescale 1ns/100ps

// Word stream into and out of one FIFO
interface spis_fifo_if #(
  parameter int W  = 32,
  parameter int CW = 4
) ();
  logic          pushValid;
  logic          pushReady;
  logic [W-1:0]  pushData;
  logic          popValid;
  logic          popReady;
  logic [W-1:0]  popData;
  logic [CW-1:0] count;

  modport store (input pushValid, pushData, popReady,
                 output pushReady, popValid, popData, count);
  modport user  (output pushValid, pushData, popReady,
                 input pushReady, popValid, popData, count);
endinterface

// ==== design/spis_fifo.sv ====
`timescale 1ns/100ps

module spis_fifo
  import spis_pkg::*;
#(
  parameter int W     = 32,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input logic   clk,
  input logic   rst_n,
  // Stream port
  spis_fifo_if.store fif
);

  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0]           wp;
    logic [PW-1:0]           rp;
    logic [CW-1:0]           cnt;
  } spis_fifo_st_t;

  spis_fifo_st_t r;
  spis_fifo_st_t n;
  logic          doPush;
  logic          doPop;

  // Pointer advance with wrap at the depth
  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction

  // Honest flags from the fill count
  assign fif.pushReady = (r.cnt != CW'(DEPTH));
  assign fif.popValid  = (r.cnt != '0);
  assign fif.popData   = r.mem[r.rp];
  assign fif.count     = r.cnt;
  assign doPush        = fif.pushValid & fif.pushReady;
  assign doPop         = fif.popReady & fif.popValid;

  // Next state
  always_comb
  begin
    n = r;
    if (doPush)
    begin
      n.mem[r.wp] = fif.pushData;
      n.wp        = bump(r.wp);
    end
    if (doPop)
    begin
      n.rp = bump(r.rp);
    end
    if (doPush && !doPop)
    begin
      n.cnt = CW'(r.cnt + 1'b1);
    end
    else if (doPop && !doPush)
    begin
      n.cnt = CW'(r.cnt - 1'b1);
    end
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      r <= '0;
    end
    else
    begin
      r <= n;
    end
  end
endmodule

// ==== design/spis_sync.sv ====
`timescale 1ns/100ps

module spis_sync
  import spis_pkg::*;
#(
  parameter int         W         = 3,
  parameter logic [2:0] RESET_VAL = 3'h0
) (
  // Clock and reset
  input  logic         clk,
  input  logic         rst_n,
  // Pins and their sampled forms
  input  logic [W-1:0] pins,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } spis_sync_st_t;

  spis_sync_st_t r;
  spis_sync_st_t n;

  // Two-stage sampling, third stage only for edges
  always_comb
  begin
    n    = r;
    n.s1 = pins;
    n.s2 = r.s1;
    n.s3 = r.s2;
  end

  assign level = r.s2;
  assign rise  = r.s2 & ~r.s3;
  assign fall  = ~r.s2 & r.s3;

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      r <= {3{W'(RESET_VAL)}};
    end
    else
    begin
      r <= n;
    end
  end
endmodule

// ==== bench/spis_status_flags_sva.sv ====
`timescale 1ns/100ps
`include "spis_defines.svh"

module spis_status_flags_sva #(
  parameter int WORD_BITS = 32,
  parameter int DEPTH     = 8
) (
  // Clock and reset
  input logic        clk,
  input logic        rst_n,
  // Register bus
  input logic [4:0]  avs_address,
  input logic        avs_read,
  input logic        avs_write,
  input logic [31:0] avs_writedata,
  input logic [31:0] avs_readdata,
  input logic        avs_waitrequest,
  // Link and interrupt
  input logic        sck,
  input logic        sdi,
  input logic        peripheralSelectN,
  input logic        sdo,
  input logic        sdoOe,
  input logic        irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Shadow of the enable register being all zero
  logic ienZero_r;
  always_ff @(posedge clk)
    if (!rst_n)
      ienZero_r <= 1'b1;
    else if (avs_write && !avs_waitrequest && avs_address == `SPIS_OFF_IEN)
      ienZero_r <= (avs_writedata & `SPIS_IEN_MASK) == 32'h0;

  // Read steps
  sequence readAccept;
    avs_read && !avs_waitrequest;
  endsequence
  sequence statusRead;
    readAccept ##0 avs_address == `SPIS_OFF_STATUS;
  endsequence

  a_read_one_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 readAccept)
    else $error("read not answered after one wait state");
  a_write_no_wait: assert property (avs_write && avs_address != `SPIS_OFF_TXDATA
    |-> !avs_waitrequest)
    else $error("register write stalled");
  a_busy_on_select: assert property ($fell(peripheralSelectN) |-> ##[2:5] sdoOe)
    else $error("busy not raised after select fall");
  a_busy_off_deselect: assert property ($rose(peripheralSelectN) |-> ##[2:5] !sdoOe)
    else $error("busy not dropped after select rise");
  a_busy_bit_read: assert property (statusRead |-> avs_readdata[24] == $past(sdoOe))
    else $error("busy bit differs from link activity");
  a_reserved_bits_zero: assert property (statusRead |-> avs_readdata[31:25] == 7'h0
    && avs_readdata[23:14] == 10'h0 && avs_readdata[7:2] == 6'h0)
    else $error("reserved status bits not zero");
  a_irq_after_reset: assert property ($rose(rst_n) |-> !irq)
    else $error("interrupt high after reset");
  a_irq_all_masked: assert property ($past(ienZero_r) |-> !irq)
    else $error("interrupt high with all enables clear");
endmodule

bind spis_status_flags spis_status_flags_sva #(.WORD_BITS(WORD_BITS), .DEPTH(DEPTH)) chk (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .sck(sck), .sdi(sdi),
  .peripheralSelectN(peripheralSelectN), .sdo(sdo), .sdoOe(sdoOe), .irq(irq));

// ==== bench/spis_peer_model.sv ====
`timescale 1ns/100ps

module spis_peer_model (
  // Clock reference
  input  logic        clk,
  // Link pins
  output logic        sck,
  output logic        sdi,
  output logic        peripheralSelectN,
  input  logic        sdo,
  // Last word seen on the data output
  output logic [31:0] rxWord
);
  initial
  begin
    sck = 1'b0;
    sdi = 1'b0;
    peripheralSelectN = 1'b1;
    rxWord = 32'h0;
  end

  // One frame of words, MSB first, clock idle low, 125 ns bit period
  task automatic frame(input logic [31:0] w, input int nWords);
    peripheralSelectN <= 1'b0;
    repeat (13) @(posedge clk);
    repeat (nWords)
    begin
      for (int i = 31; i >= 0; i--)
      begin
        sdi <= w[i];
        repeat (12) @(posedge clk);
        sck <= 1'b1;
        rxWord <= {rxWord[30:0], sdo};
        repeat (13) @(posedge clk);
        sck <= 1'b0;
      end
    end
    repeat (13) @(posedge clk);
    peripheralSelectN <= 1'b1;
    sdi <= ~w[0];  // Released line does not keep the last bit
    repeat (13) @(posedge clk);
  endtask
endmodule

// ==== bench/spis_status_flags_tb.sv ====
`timescale 1ns/100ps
`include "spis_defines.svh"

module spis_status_flags_tb import spis_pkg::*;;
  localparam logic [31:0] WORD_X = 32'hc3a5_0f96;
  localparam logic [31:0] WORD_M = 32'h5a5a_0ff0;
  logic        clk;
  logic        rst_n;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        sck;
  logic        sdi;
  logic        peripheralSelectN;
  logic        sdo;
  logic        sdoOe;
  logic        irq;
  logic [31:0] peerWord;
  int          errors;
  int          nChecks;

  spis_status_flags dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sck(sck),
    .sdi(sdi), .peripheralSelectN(peripheralSelectN), .sdo(sdo), .sdoOe(sdoOe), .irq(irq));
  spis_peer_model peer (.clk(clk), .sck(sck), .sdi(sdi),
    .peripheralSelectN(peripheralSelectN), .sdo(sdo), .rxWord(peerWord));

  // ----------------------------------------
  // Bus access and comparison
  // ----------------------------------------
  task automatic busXfer(input logic wr, input logic [4:0] a, input logic [31:0] d,
                         output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    // Hold the request until waitrequest is sampled low at a rising edge
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    busXfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [4:0] a, output logic [31:0] q);
    busXfer(1'b0, a, 32'h0, q);
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    nChecks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic printVerdict();
    $display("Checks %0d, mismatches %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset state, unmapped read, transmit request at the watermark edge
  task automatic tReset();
    logic [31:0] v;
    rd(`SPIS_OFF_STATUS, v);
    check(v, 32'h0000_0001);
    rd(5'h02, v);
    check(v, 32'h0000_0000);
    wr(`SPIS_OFF_WATER, 32'h0000_0001);
    wr(`SPIS_OFF_TXDATA, WORD_X);
    rd(`SPIS_OFF_STATUS, v);
    check(v & 32'h3, 32'h1);
    wr(`SPIS_OFF_TXDATA, WORD_M);
    rd(`SPIS_OFF_STATUS, v);
    check(v & 32'h3, 32'h0);
  endtask

  // Slave frame: busy, word and frame done, write-one clear, masking
  task automatic tFrame();
    logic [31:0] v;
    wr(`SPIS_OFF_IEN, 32'h0000_0200);
    fork
      peer.frame(WORD_M, 1);
      begin
        repeat (300) @(posedge clk);
        rd(`SPIS_OFF_STATUS, v);
        check(v & 32'h0100_0000, 32'h0100_0000);
      end
    join
    check(peerWord, WORD_X);
    rd(`SPIS_OFF_STATUS, v);
    check(v, 32'h0000_0303);
    check({31'h0, irq}, 32'h1);
    wr(`SPIS_OFF_STATUS, 32'h0);
    rd(`SPIS_OFF_STATUS, v);
    check(v, 32'h0000_0303);
    wr(`SPIS_OFF_STATUS, 32'h0000_0200);
    rd(`SPIS_OFF_STATUS, v);
    check(v, 32'h0000_0103);
    check({31'h0, irq}, 32'h0);
    wr(`SPIS_OFF_STATUS, 32'h0000_3f00);
    rd(`SPIS_OFF_RXDATA, v);
    check(v, WORD_M);
  endtask

  // Master frames with empty transmit side under every match setting
  task automatic tMatch();
    logic [31:0] v;
    logic        hit;
    wr(`SPIS_OFF_MATCHA, WORD_M);
    wr(`SPIS_OFF_MATCHB, WORD_X);
    for (int c = 0; c < 4; c++)
    begin
      hit = (c == SPIS_MATCH_A) || (c == SPIS_MATCH_EITHER);
      wr(`SPIS_OFF_CTRL, {29'h0, c[1:0], 1'b1});
      peer.frame(WORD_M, 1);
      rd(`SPIS_OFF_STATUS, v);
      check(v, {18'h0, hit, 13'h0f03});
      wr(`SPIS_OFF_STATUS, 32'h0000_3f00);
      rd(`SPIS_OFF_RXDATA, v);
      check(v, WORD_M);
    end
  endtask

  // Receive overflow, then drain, clear and recover
  task automatic tOverflow();
    logic [31:0] v;
    wr(`SPIS_OFF_IEN, 32'h0000_1000);
    rd(`SPIS_OFF_IEN, v);
    check(v, 32'h0000_1000);
    peer.frame(WORD_X, 9);
    rd(`SPIS_OFF_STATUS, v);
    check(v & 32'h0000_1002, 32'h0000_1002);
    check({31'h0, irq}, 32'h1);
    for (int i = 0; i < 8; i++)
      rd(`SPIS_OFF_RXDATA, v);
    check(v, WORD_X);
    wr(`SPIS_OFF_STATUS, 32'h0000_1800);
    rd(`SPIS_OFF_STATUS, v);
    check(v & 32'h0000_1803, 32'h1);
    check({31'h0, irq}, 32'h0);
    peer.frame(WORD_M, 1);
    rd(`SPIS_OFF_STATUS, v);
    check(v & 32'h0000_1002, 32'h0000_0002);
    rd(`SPIS_OFF_RXDATA, v);
    check(v, WORD_M);
  endtask

  // ----------------------------------------
  // Clock, sequence and watchdog
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial
  begin
    rst_n = 1'b0;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    errors = 0;
    nChecks = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    tReset();
    tFrame();
    tMatch();
    tOverflow();
    printVerdict();
  end

  initial
  begin
    repeat (40000) @(posedge clk);
    errors++;
    printVerdict();
  end
endmodule
